// >>> hw/qbp_pkg.sv
// Purpose: Constants and types shared by the quasi-bidirectional port block
// Assumes: 250 MHz core clock
// Notes: Bit positions of the third port and its alternate functions
package qbp_pkg;
	localparam int QBP_WIDTH = 8;
	localparam logic [7:0] QBP_LATCH_RESET = 8'hFF;
	localparam int QBP_BIT_RXD = 0;
	localparam int QBP_BIT_TXD = 1;
	localparam int QBP_BIT_IRQ0 = 2;
	localparam int QBP_BIT_IRQ1 = 3;
	localparam int QBP_BIT_CNT0 = 4;
	localparam int QBP_BIT_CNT1 = 5;
	localparam int QBP_BIT_WRS = 6;
	localparam int QBP_BIT_RDS = 7;
	localparam int QBP_CLK_PERIOD_PS = 4000;
	localparam int QBP_GLITCH_NS = 50;
	// Longest pulse rejected, rounded up so a 50 ns glitch never gets through
	localparam int QBP_GLITCH_CYC = (QBP_GLITCH_NS * 1000 + QBP_CLK_PERIOD_PS - 1) / QBP_CLK_PERIOD_PS;
	// Access kinds on the core side
	typedef enum logic [3:0] {
		QBP_OP_NONE = 4'h0,
		QBP_OP_MOV = 4'h1,
		QBP_OP_ANL = 4'h2,
		QBP_OP_ORL = 4'h3,
		QBP_OP_XRL = 4'h4,
		QBP_OP_JBC = 4'h5,
		QBP_OP_CPL = 4'h6,
		QBP_OP_INC = 4'h7,
		QBP_OP_DEC = 4'h8,
		QBP_OP_DJNZ = 4'h9,
		QBP_OP_MOVC = 4'hA,
		QBP_OP_CLR = 4'hB,
		QBP_OP_SETB = 4'hC,
		QBP_OP_READ = 4'hD
	} qbp_op_type;
endpackage

// >>> hw/qbp_filt_if.sv
// Purpose: Carries raw synchronised levels into the glitch filter and filtered levels out
// Assumes: Single clock domain
// Notes: One lane per filtered pin
`timescale 1ns/1ps
interface qbp_filt_if;
	logic [1:0] raw;
	logic [1:0] clean;
	modport filt (input raw, output clean);
	modport user (output raw, input clean);
endinterface

// >>> hw/qbp_glitch_filter.sv
// Purpose: Rejects pulses of up to the glitch time on the serial pins toward the two-wire logic
// Assumes: Inputs already synchronised
// Notes: A level must stay stable longer than the glitch time before it is passed
`timescale 1ns/1ps
module qbp_glitch_filter
	import qbp_pkg::*;
#(
	parameter int LANES = 2,
	parameter int HOLD = QBP_GLITCH_CYC
) (
	input wire logic clock,
	input wire logic srst,
	qbp_filt_if.filt port
);
	// Counter is eight bits wide, so longer holds cannot be served
	if (LANES != 2 || HOLD < 1 || HOLD > 250) begin : g_bad_params
		$error("qbp_glitch_filter: bad parameters");
	end
	logic [7:0] count [LANES];
	logic [7:0] next_count [LANES];
	logic [LANES-1:0] clean;
	logic [LANES-1:0] next_clean;
	always_comb begin
		for (int i = 0; i < LANES; i++) begin
			next_count[i] = 8'h00;
			next_clean[i] = clean[i];
			if (port.raw[i] != clean[i]) begin
				// Accept only after HOLD+1 stable cycles
				if (count[i] == 8'(HOLD)) begin
					next_clean[i] = port.raw[i];
				end else begin
					next_count[i] = count[i] + 8'h01;
				end
			end
		end
	end
	always_ff @(posedge clock) begin
		if (srst) begin
			for (int i = 0; i < LANES; i++) begin
				count[i] <= 8'h00;
			end
			clean <= '1;
		end else begin
			count <= next_count;
			clean <= next_clean;
		end
	end
	assign port.clean = clean;
endmodule

// >>> hw/qbp_port.sv
// Purpose: Third parallel port with quasi-bidirectional pads, alternate functions and serial pin pads
// Assumes: Core issues one port access per cycle; pins are sampled through two flip-flops
// Notes: Pad strengths modelled as strong-low enable, strong-high enable and weak pull-up enable
`timescale 1ns/1ps
module qbp_port
	import qbp_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire qbp_op_type op,
	input wire logic [2:0] op_bit,
	input wire logic [7:0] op_data,
	input wire logic op_carry,
	output logic [7:0] read_data,
	output logic jump_taken,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_drive_low,
	output logic [7:0] pin_drive_high,
	output logic [7:0] pin_weak_up,
	input wire logic uart_data_out,
	input wire logic uart_clock_out,
	input wire logic spi_miso_out,
	input wire logic spi_miso_en,
	input wire logic pwm0_out,
	input wire logic pwm1_out,
	input wire logic pwm_select,
	input wire logic xmem_active,
	input wire logic xmem_write_n,
	input wire logic xmem_read_n,
	output logic uart_rx_in,
	output logic ext_irq_zero_in,
	output logic ext_irq_one_in,
	output logic count_input_zero,
	output logic count_input_one,
	output logic pwm_ext_clock_in,
	output logic spi_miso_in,
	input wire logic serial_periph_select,
	input wire logic twi_master,
	input wire logic sw_clock_level,
	input wire logic sw_data_level,
	input wire logic spi_clock_out,
	input wire logic spi_clock_oe,
	input wire logic spi_mosi_out,
	input wire logic spi_mosi_oe,
	input wire logic twi_clock_out,
	input wire logic twi_data_out,
	input wire logic serial_clock_pin_in,
	input wire logic serial_data_pin_in,
	output logic serial_clock_pin_low,
	output logic serial_clock_pin_high,
	output logic serial_data_pin_low,
	output logic serial_data_pin_high,
	output logic spi_clock_in,
	output logic spi_mosi_in,
	output logic twi_clock_in,
	output logic twi_data_in
);
	logic [7:0] third_port_latch;
	logic [7:0] next_latch;
	logic [7:0] next_read;
	logic next_jump;
	logic [7:0] pin_meta;
	logic [7:0] pin_sync;
	logic [1:0] ser_meta;
	logic [1:0] ser_sync;
	logic [7:0] alt_level;
	logic [7:0] next_low;
	logic [7:0] next_high;
	logic [7:0] next_weak;
	logic next_sc_low;
	logic next_sc_high;
	logic next_sd_low;
	logic next_sd_high;
	logic [1:0] filt_clean;
	qbp_filt_if filt_bus ();
	logic sda_last;
	logic [7:0] sda_stable;
	logic [7:0] next_sda_stable;
	function automatic logic reads_latch(input qbp_op_type o);
		// Read-modify-write class goes to the latch
		case (o)
			QBP_OP_ANL, QBP_OP_ORL, QBP_OP_XRL, QBP_OP_JBC, QBP_OP_CPL, QBP_OP_INC, QBP_OP_DEC,
			QBP_OP_DJNZ, QBP_OP_MOVC, QBP_OP_CLR, QBP_OP_SETB: reads_latch = 1'b1;
			default: reads_latch = 1'b0;
		endcase
	endfunction
	function automatic logic [7:0] with_bit(input logic [7:0] b, input logic [2:0] idx, input logic v);
		logic [7:0] r;
		r = b;
		r[idx] = v;
		with_bit = r;
	endfunction
	always_comb begin
		logic [7:0] src;
		src = reads_latch(op) ? third_port_latch : pin_sync;
		next_latch = third_port_latch;
		next_read = read_data;
		next_jump = 1'b0;
		case (op)
			QBP_OP_MOV: next_latch = op_data;
			QBP_OP_ANL: next_latch = src & op_data;
			QBP_OP_ORL: next_latch = src | op_data;
			QBP_OP_XRL: next_latch = src ^ op_data;
			QBP_OP_INC: next_latch = src + 8'h01;
			QBP_OP_DEC: next_latch = src - 8'h01;
			QBP_OP_DJNZ: begin
				next_latch = src - 8'h01;
				next_jump = (src != 8'h01);
			end
			// Whole byte in, one bit changed, whole byte out
			QBP_OP_JBC: begin
				next_latch = with_bit(src, op_bit, 1'b0);
				next_jump = src[op_bit];
			end
			QBP_OP_CPL: next_latch = with_bit(src, op_bit, ~src[op_bit]);
			QBP_OP_MOVC: next_latch = with_bit(src, op_bit, op_carry);
			QBP_OP_CLR: next_latch = with_bit(src, op_bit, 1'b0);
			QBP_OP_SETB: next_latch = with_bit(src, op_bit, 1'b1);
			QBP_OP_READ: next_read = src;
			default: next_latch = third_port_latch;
		endcase
		if (op != QBP_OP_NONE && op != QBP_OP_MOV && op != QBP_OP_READ) begin
			next_read = src;
		end
	end
	always_comb begin
		alt_level = 8'hFF;
		alt_level[QBP_BIT_RXD] = uart_data_out;
		alt_level[QBP_BIT_TXD] = uart_clock_out;
		// MISO drives through the same quasi pad as the latch
		alt_level[QBP_BIT_IRQ1] = pwm_select ? pwm1_out : (spi_miso_en ? spi_miso_out : 1'b1);
		alt_level[QBP_BIT_CNT0] = pwm_select ? pwm0_out : 1'b1;
		alt_level[QBP_BIT_WRS] = xmem_active ? xmem_write_n : 1'b1;
		alt_level[QBP_BIT_RDS] = xmem_active ? xmem_read_n : 1'b1;
		for (int i = 0; i < QBP_WIDTH; i++) begin
			// Latch zero forces low whatever the peripheral does, unless the PWM override below takes the pin
			next_low[i] = ~third_port_latch[i] | ~alt_level[i];
			next_weak[i] = ~next_low[i];
			next_high[i] = 1'b0;
		end
		// PWM override drives push-pull, ignoring the latch
		if (pwm_select) begin
			next_low[QBP_BIT_IRQ1] = ~pwm1_out;
			next_high[QBP_BIT_IRQ1] = pwm1_out;
			next_weak[QBP_BIT_IRQ1] = 1'b0;
			next_low[QBP_BIT_CNT0] = ~pwm0_out;
			next_high[QBP_BIT_CNT0] = pwm0_out;
			next_weak[QBP_BIT_CNT0] = 1'b0;
		end
		if (serial_periph_select) begin
			// Push-pull under SPI control
			next_sc_high = spi_clock_oe & spi_clock_out;
			next_sc_low = spi_clock_oe & ~spi_clock_out;
			next_sd_high = spi_mosi_oe & spi_mosi_out;
			next_sd_low = spi_mosi_oe & ~spi_mosi_out;
		end else begin
			// Open drain, weak pull-up only
			next_sc_high = 1'b0;
			next_sd_high = 1'b0;
			// Software levels take over in master mode
			next_sc_low = twi_master ? ~sw_clock_level : ~twi_clock_out;
			next_sd_low = twi_master ? ~sw_data_level : ~twi_data_out;
		end
	end
	assign filt_bus.raw = ser_sync;
	assign filt_clean = filt_bus.clean;
	qbp_glitch_filter #(.LANES(2), .HOLD(QBP_GLITCH_CYC)) u_filter (
		.clock(clock),
		.srst(srst),
		.port(filt_bus)
	);
	// Run length of the synchronised data level, kept only for the glitch check
	always_comb begin
		next_sda_stable = 8'h00;
		if (ser_sync[1] == sda_last) begin
			next_sda_stable = (sda_stable == 8'hFF) ? sda_stable : sda_stable + 8'h01;
		end
	end
	always_ff @(posedge clock) begin
		if (srst) begin
			sda_last <= 1'b1;
			sda_stable <= 8'h00;
		end else begin
			sda_last <= ser_sync[1];
			sda_stable <= next_sda_stable;
		end
	end
	always_ff @(posedge clock) begin
		if (srst) begin
			third_port_latch <= QBP_LATCH_RESET;
			read_data <= 8'h00;
			jump_taken <= 1'b0;
			pin_meta <= 8'hFF;
			pin_sync <= 8'hFF;
			ser_meta <= 2'h3;
			ser_sync <= 2'h3;
			pin_drive_low <= 8'h00;
			pin_drive_high <= 8'h00;
			pin_weak_up <= 8'hFF;
			serial_clock_pin_low <= 1'b0;
			serial_clock_pin_high <= 1'b0;
			serial_data_pin_low <= 1'b0;
			serial_data_pin_high <= 1'b0;
			uart_rx_in <= 1'b1;
			ext_irq_zero_in <= 1'b1;
			ext_irq_one_in <= 1'b1;
			count_input_zero <= 1'b1;
			count_input_one <= 1'b1;
			pwm_ext_clock_in <= 1'b1;
			spi_miso_in <= 1'b1;
			spi_clock_in <= 1'b1;
			spi_mosi_in <= 1'b1;
			twi_clock_in <= 1'b1;
			twi_data_in <= 1'b1;
		end else begin
			third_port_latch <= next_latch;
			read_data <= next_read;
			jump_taken <= next_jump;
			pin_meta <= pin_in;
			pin_sync <= pin_meta;
			ser_meta <= {serial_data_pin_in, serial_clock_pin_in};
			ser_sync <= ser_meta;
			pin_drive_low <= next_low;
			pin_drive_high <= next_high;
			pin_weak_up <= next_weak;
			serial_clock_pin_low <= next_sc_low;
			serial_clock_pin_high <= next_sc_high;
			serial_data_pin_low <= next_sd_low;
			serial_data_pin_high <= next_sd_high;
			uart_rx_in <= pin_sync[QBP_BIT_RXD];
			ext_irq_zero_in <= pin_sync[QBP_BIT_IRQ0];
			ext_irq_one_in <= pin_sync[QBP_BIT_IRQ1];
			count_input_zero <= pin_sync[QBP_BIT_CNT0];
			count_input_one <= pin_sync[QBP_BIT_CNT1];
			pwm_ext_clock_in <= pin_sync[QBP_BIT_CNT0];
			spi_miso_in <= pin_sync[QBP_BIT_IRQ1];
			spi_clock_in <= ser_sync[0];
			spi_mosi_in <= ser_sync[1];
			twi_clock_in <= filt_clean[0];
			twi_data_in <= filt_clean[1];
		end
	end
	never_low_when_one_a: assert property (@(posedge clock) disable iff (srst)
		(&third_port_latch && !pwm_select && !xmem_active && uart_data_out && uart_clock_out && !spi_miso_en)
		|=> pin_drive_low == 8'h00)
		else $error("pin pulled low with latch at one");
	zero_drives_low_a: assert property (@(posedge clock) disable iff (srst)
		(!pwm_select && third_port_latch != 8'hFF) |=> ((pin_drive_low & ~$past(third_port_latch)) == ~$past(third_port_latch)))
		else $error("latch zero not driving low");
	alt_stuck_low_a: assert property (@(posedge clock) disable iff (srst)
		(!third_port_latch[QBP_BIT_TXD]) |=> pin_drive_low[QBP_BIT_TXD] && !pin_weak_up[QBP_BIT_TXD])
		else $error("alternate function passed with latch clear");
	pwm_override_a: assert property (@(posedge clock) disable iff (srst)
		pwm_select |=> pin_drive_high[QBP_BIT_CNT0] == $past(pwm0_out) && pin_drive_high[QBP_BIT_IRQ1] == $past(pwm1_out))
		else $error("PWM did not override latch");
	twi_no_strong_up_a: assert property (@(posedge clock) disable iff (srst)
		!serial_periph_select |=> !serial_clock_pin_high && !serial_data_pin_high)
		else $error("strong pull-up in two-wire mode");
	spi_push_pull_a: assert property (@(posedge clock) disable iff (srst)
		(serial_periph_select && spi_clock_oe) |=> serial_clock_pin_high == $past(spi_clock_out)
		&& serial_clock_pin_low == !$past(spi_clock_out))
		else $error("SPI clock pin not push-pull");
	sw_drive_a: assert property (@(posedge clock) disable iff (srst)
		(!serial_periph_select && twi_master) |=> serial_data_pin_low == !$past(sw_data_level))
		else $error("software data level not on pin");
	rmw_reads_latch_a: assert property (@(posedge clock) disable iff (srst)
		(op == QBP_OP_ORL) |=> read_data == $past(third_port_latch))
		else $error("read-modify-write did not read latch");
	setb_one_bit_a: assert property (@(posedge clock) disable iff (srst)
		(op == QBP_OP_SETB) |=> third_port_latch == ($past(third_port_latch) | (8'h01 << $past(op_bit))))
		else $error("set bit touched other bits");
	glitch_reject_a: assert property (@(posedge clock) disable iff (srst)
		$changed(twi_data_in) |-> $past(sda_stable) >= 8'(QBP_GLITCH_CYC) && $past(sda_last) == twi_data_in)
		else $error("short pulse reached two-wire logic");
	read_pin_a: assert property (@(posedge clock) disable iff (srst)
		(op == QBP_OP_READ) |=> read_data == $past(pin_sync))
		else $error("plain read did not return pin level");
	jbc_clears_a: assert property (@(posedge clock) disable iff (srst)
		(op == QBP_OP_JBC) |=> third_port_latch == ($past(third_port_latch) & ~(8'h01 << $past(op_bit)))
		&& jump_taken == $past(third_port_latch[op_bit]))
		else $error("jump and clear did not use latch");
	miso_quasi_a: assert property (@(posedge clock) disable iff (srst)
		(!pwm_select && spi_miso_en && !spi_miso_out) |=> pin_drive_low[QBP_BIT_IRQ1] && !pin_drive_high[QBP_BIT_IRQ1])
		else $error("MISO low not on quasi pad");
	strobe_pass_a: assert property (@(posedge clock) disable iff (srst)
		(xmem_active && third_port_latch[QBP_BIT_WRS]) |=> pin_drive_low[QBP_BIT_WRS] == !$past(xmem_write_n))
		else $error("write strobe not on its pin");
	pwm_cover_c: cover property (@(posedge clock) disable iff (srst) pwm_select && pwm0_out);
	djnz_cover_c: cover property (@(posedge clock) disable iff (srst) op == QBP_OP_DJNZ ##1 jump_taken);
	spi_cover_c: cover property (@(posedge clock) disable iff (srst) serial_periph_select && spi_clock_oe);
	twi_cover_c: cover property (@(posedge clock) disable iff (srst) $fell(twi_data_in));
endmodule

// >>> tb/qbp_pin_model.sv
// Purpose: Far side of the third port, external loads that may pull pins low
// Assumes: Pads given as strong-low, strong-high and weak pull-up enables
// Notes: A strong drive always wins over an external pull-down
`timescale 1ns/1ps
module qbp_pin_model (
	input wire logic [7:0] drive_low,
	input wire logic [7:0] drive_high,
	input wire logic [7:0] weak_up,
	input wire logic [7:0] ext_low,
	output logic [7:0] pin
);
	// A weak pull-up loses to an external load, so a quasi input reads what the load sets
	assign pin = ~drive_low & (drive_high | (weak_up & ~ext_low));
endmodule

// >>> tb/qbp_port_tb_top.sv
// Purpose: Self-checking bench of the third port against an integer reference of its latch
// Assumes: Inputs change at the falling edge; pad outputs settle two cycles after an access
// Notes: Alternate outputs are held released unless a scenario exercises them
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module qbp_port_tb_top;
	import qbp_pkg::*;
	logic clock = 1'b0;
	logic srst = 1'b1;
	qbp_op_type op = QBP_OP_NONE;
	logic [2:0] op_bit = 3'h0;
	logic [7:0] op_data = 8'h00, ext_low = 8'h00, lat = 8'hFF, exp_rd = 8'h00;
	logic op_carry = 1'b0, exp_jump, seen_jump, jump_taken;
	logic [7:0] read_data, pin_in, pin_drive_low, pin_drive_high, pin_weak_up;
	logic uart_data_out = 1'b1, uart_clock_out = 1'b1, spi_miso_out = 1'b1, spi_miso_en = 1'b0;
	logic pwm0_out = 1'b0, pwm1_out = 1'b0, pwm_select = 1'b0;
	logic xmem_active = 1'b0, xmem_write_n = 1'b1, xmem_read_n = 1'b1;
	logic uart_rx_in, ext_irq_zero_in, ext_irq_one_in, count_input_zero, count_input_one;
	logic pwm_ext_clock_in, spi_miso_in;
	logic serial_periph_select = 1'b0, twi_master = 1'b0, sw_clock_level = 1'b1, sw_data_level = 1'b1;
	logic spi_clock_out = 1'b1, spi_clock_oe = 1'b0, spi_mosi_out = 1'b1, spi_mosi_oe = 1'b0;
	logic twi_clock_out = 1'b1, twi_data_out = 1'b1, serial_clock_pin_in = 1'b1, serial_data_pin_in = 1'b1;
	logic serial_clock_pin_low, serial_clock_pin_high, serial_data_pin_low, serial_data_pin_high;
	logic spi_clock_in, spi_mosi_in, twi_clock_in, twi_data_in;
	logic [31:0] seed = 32'hD1A42AF3;
	int errors = 0;
	int checks = 0;
	int cyc = 0;

	always #2 clock = ~clock;

	qbp_port i_qbp_port (.clock, .srst, .op, .op_bit, .op_data, .op_carry, .read_data, .jump_taken,
		.pin_in, .pin_drive_low, .pin_drive_high, .pin_weak_up, .uart_data_out, .uart_clock_out,
		.spi_miso_out, .spi_miso_en, .pwm0_out, .pwm1_out, .pwm_select, .xmem_active, .xmem_write_n,
		.xmem_read_n, .uart_rx_in, .ext_irq_zero_in, .ext_irq_one_in, .count_input_zero, .count_input_one,
		.pwm_ext_clock_in, .spi_miso_in, .serial_periph_select, .twi_master, .sw_clock_level,
		.sw_data_level, .spi_clock_out, .spi_clock_oe, .spi_mosi_out, .spi_mosi_oe, .twi_clock_out,
		.twi_data_out, .serial_clock_pin_in, .serial_data_pin_in, .serial_clock_pin_low,
		.serial_clock_pin_high, .serial_data_pin_low, .serial_data_pin_high, .spi_clock_in, .spi_mosi_in,
		.twi_clock_in, .twi_data_in);

	qbp_pin_model i_qbp_pin_model (.drive_low(pin_drive_low), .drive_high(pin_drive_high),
		.weak_up(pin_weak_up), .ext_low(ext_low), .pin(pin_in));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic conclude;
		if (errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// One access, then the reference updates and read value, jump pulse and pads are compared
	task automatic do_op(input qbp_op_type o, input logic [2:0] b, input logic [7:0] d, input logic c);
		logic [7:0] old;
		old = lat;
		exp_jump = 1'b0;
		@(negedge clock);
		op = o;
		op_bit = b;
		op_data = d;
		op_carry = c;
		@(negedge clock);
		op = QBP_OP_NONE;
		seen_jump = jump_taken;
		@(negedge clock);
		seen_jump = seen_jump | jump_taken;
		case (o)
			QBP_OP_MOV: lat = d;
			QBP_OP_ANL: lat = old & d;
			QBP_OP_ORL: lat = old | d;
			QBP_OP_XRL: lat = old ^ d;
			QBP_OP_JBC: begin
				exp_jump = old[b];
				lat[b] = 1'b0;
			end
			QBP_OP_CPL: lat[b] = ~old[b];
			QBP_OP_INC: lat = old + 8'h01;
			QBP_OP_DEC: lat = old - 8'h01;
			QBP_OP_DJNZ: begin
				lat = old - 8'h01;
				exp_jump = (lat != 8'h00);
			end
			QBP_OP_MOVC: lat[b] = c;
			QBP_OP_CLR: lat[b] = 1'b0;
			QBP_OP_SETB: lat[b] = 1'b1;
			default: ;
		endcase
		if (o == QBP_OP_READ)
			exp_rd = old & ~ext_low;
		else if (o != QBP_OP_NONE && o != QBP_OP_MOV)
			exp_rd = old;
		`CHK(read_data, exp_rd)
		`CHK(seen_jump, exp_jump)
		wait_cyc(2);
		`CHK(pin_drive_low, ~lat)
	endtask

	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			conclude();
		end
	end

	initial begin
		repeat (8) @(posedge clock);
		@(negedge clock);
		srst = 1'b0;
		`CHK(pin_weak_up, 8'hFF)
		do_op(QBP_OP_ANL, 3'h0, 8'hFF, 1'b0);
		for (int k = 0; k < 14; k++) begin
			seed = lfsr(seed);
			do_op(qbp_op_type'(k), seed[2:0], seed[15:8], seed[16]);
		end
		// Random mix keeps hitting read-modify-write after read-modify-write
		repeat (200) begin
			seed = lfsr(seed);
			do_op(qbp_op_type'(seed[3:0] % 14), seed[6:4], seed[15:8], seed[16]);
		end
		do_op(QBP_OP_MOV, 3'h0, 8'hFF, 1'b0);
		ext_low = 8'h24;
		wait_cyc(2);
		do_op(QBP_OP_READ, 3'h0, 8'h00, 1'b0);
		`CHK(ext_irq_zero_in, 1'b0)
		`CHK(count_input_one, 1'b0)
		`CHK(uart_rx_in, 1'b1)
		ext_low = 8'h18;
		wait_cyc(6);
		`CHK({ext_irq_one_in, count_input_zero, pwm_ext_clock_in, spi_miso_in, ext_irq_zero_in}, 5'h01)
		ext_low = 8'h00;
		do_op(QBP_OP_CLR, 3'h1, 8'h00, 1'b0);
		wait_cyc(4);
		`CHK(pin_drive_low[1], 1'b1)
		do_op(QBP_OP_SETB, 3'h1, 8'h00, 1'b0);
		uart_data_out = 1'b0;
		wait_cyc(4);
		`CHK(pin_drive_low[1:0], 2'h1)
		uart_data_out = 1'b1;
		uart_clock_out = 1'b0;
		wait_cyc(4);
		`CHK(pin_drive_low[1:0], 2'h2)
		uart_clock_out = 1'b1;
		do_op(QBP_OP_CLR, 3'h3, 8'h00, 1'b0);
		pwm_select = 1'b1;
		pwm1_out = 1'b1;
		wait_cyc(4);
		`CHK({pin_drive_high[3], pin_drive_low[3]}, 2'h2)
		`CHK({pin_drive_high[4], pin_drive_low[4]}, 2'h1)
		pwm_select = 1'b0;
		pwm1_out = 1'b0;
		do_op(QBP_OP_SETB, 3'h3, 8'h00, 1'b0);
		spi_miso_en = 1'b1;
		spi_miso_out = 1'b0;
		xmem_active = 1'b1;
		xmem_write_n = 1'b0;
		wait_cyc(4);
		`CHK(pin_drive_low[3], 1'b1)
		`CHK(pin_drive_low[7:6], 2'h1)
		spi_miso_en = 1'b0;
		xmem_active = 1'b0;
		xmem_write_n = 1'b1;
		twi_data_out = 1'b0;
		wait_cyc(4);
		`CHK({serial_clock_pin_high, serial_data_pin_low}, 2'h1)
		twi_data_out = 1'b1;
		serial_periph_select = 1'b1;
		spi_clock_oe = 1'b1;
		spi_mosi_oe = 1'b1;
		wait_cyc(4);
		`CHK({serial_clock_pin_high, serial_clock_pin_low}, 2'h2)
		`CHK({serial_data_pin_high, serial_data_pin_low}, 2'h2)
		spi_clock_out = 1'b0;
		wait_cyc(4);
		`CHK({serial_clock_pin_high, serial_clock_pin_low}, 2'h1)
		serial_periph_select = 1'b0;
		twi_master = 1'b1;
		sw_clock_level = 1'b0;
		wait_cyc(4);
		`CHK(serial_clock_pin_low, 1'b1)
		sw_clock_level = 1'b1;
		sw_data_level = 1'b0;
		wait_cyc(4);
		`CHK({serial_clock_pin_low, serial_data_pin_low}, 2'h1)
		twi_master = 1'b0;
		sw_data_level = 1'b1;
		// A 48 ns low pulse must never reach the two-wire side
		serial_data_pin_in = 1'b0;
		wait_cyc(12);
		serial_data_pin_in = 1'b1;
		for (int k = 0; k < 30; k++) begin
			`CHK(twi_data_in, 1'b1)
			@(negedge clock);
		end
		serial_data_pin_in = 1'b0;
		serial_clock_pin_in = 1'b0;
		wait_cyc(40);
		`CHK(twi_data_in, 1'b0)
		`CHK(twi_clock_in, 1'b0)
		`CHK({spi_clock_in, spi_mosi_in}, 2'h0)
		conclude();
	end
endmodule
